// [hw/src_device.sv]
`timescale 1ns/1ps
module src_device
  import src_pkg::*;
#(
  parameter int unsigned RESET_LOW_CYC = RESET_LOW_WIDTH_CYC,
  parameter int unsigned RECOV_CYC [0:6] = RECOV_CYC_DEFAULT
) (
  // System
  input wire logic ref_clk,
  input wire logic nrst,
  // Supply monitor and array engine
  input wire logic supply_ok,
  input wire logic [2:0] op_kind,
  // Flash link
  src_link_if.device link,
  // State toward the array engine
  output logic ready,
  output logic write_enable_latch,
  output logic write_in_progress_flag,
  output logic quad_mode,
  output logic hw_reset_active,
  output logic soft_reset,
  output logic op_abort
);

  // Parameter checks
  generate
    if (RESET_LOW_CYC < 2 || RESET_LOW_CYC >= (1 << CNT_W)) begin : g_bad_low
      $error("reset low width count out of range");
    end
    for (genvar i = 0; i < 7; i++) begin : g_chk
      if (RECOV_CYC[i] < 1 || RECOV_CYC[i] >= (1 << CNT_W)) begin : g_bad_rec
        $error("recovery count out of range");
      end
    end
  endgenerate

  logic supply_s1_reg, supply_s2_reg;
  logic rstpin_s1_reg, rstpin_s2_reg;
  logic cs_s1_reg, cs_s2_reg, cs_s3_reg;
  logic done_s1_reg, done_s2_reg, done_s3_reg;
  logic done_reg;
  logic [7:0] cmd_op_reg;
  src_dev_state_t state_reg;
  logic [CNT_W-1:0] rlow_cnt_reg;
  logic [CNT_W-1:0] recov_cnt_reg;
  int rec_kind_reg;
  logic armed_reg, last_arm_reg;
  logic latch_reg, quad_reg, busy_reg;
  logic abort_reg, soft_reg;

  // Pin and link inputs into the reference domain
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      supply_s1_reg <= 1'b0;
      supply_s2_reg <= 1'b0;
      rstpin_s1_reg <= 1'b1;
      rstpin_s2_reg <= 1'b1;
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      cs_s3_reg <= 1'b1;
      done_s1_reg <= 1'b0;
      done_s2_reg <= 1'b0;
      done_s3_reg <= 1'b0;
    end else begin
      supply_s1_reg <= supply_ok;
      supply_s2_reg <= supply_s1_reg;
      rstpin_s1_reg <= link.reset_n;
      rstpin_s2_reg <= rstpin_s1_reg;
      cs_s1_reg <= link.cs_n;
      cs_s2_reg <= cs_s1_reg;
      cs_s3_reg <= cs_s2_reg;
      done_s1_reg <= done_reg;
      done_s2_reg <= done_s1_reg;
      done_s3_reg <= done_s2_reg;
    end
  end

  logic sys_rst;
  logic cmd_ok;
  logic frame_end;
  logic exec_now;
  logic hw_hit;
  logic reset_evt;
  logic busy_op;

  // Event decode
  assign sys_rst = !nrst || !supply_s2_reg;
  assign cmd_ok = done_s2_reg && !done_s3_reg && (state_reg == DEV_READY);
  assign frame_end = cs_s2_reg && !cs_s3_reg;
  assign exec_now = cmd_ok && (cmd_op_reg == OPC_RESET_EXEC) && armed_reg;
  assign hw_hit = !rstpin_s2_reg && (rlow_cnt_reg == CNT_W'(RESET_LOW_CYC - 1));
  assign reset_evt = exec_now || (hw_hit && state_reg != DEV_HWRST);
  assign busy_op = src_kind_idx(op_kind) >= int'(OP_PROGRAM);

  // Reset pin low-width counter
  always_ff @(posedge ref_clk) begin
    if (sys_rst || rstpin_s2_reg) begin
      rlow_cnt_reg <= '0;
    end else if (!hw_hit) begin
      rlow_cnt_reg <= rlow_cnt_reg + 1'b1;
    end
  end

  // Standby, hardware reset and recovery sequencing
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg <= DEV_READY;
      recov_cnt_reg <= '0;
      rec_kind_reg <= 0;
    end else begin
      case (state_reg)
        DEV_READY: begin
          if (hw_hit) begin
            state_reg <= DEV_HWRST;
            rec_kind_reg <= src_kind_idx(op_kind);
          end else if (exec_now) begin
            state_reg <= DEV_RECOVER;
            recov_cnt_reg <= CNT_W'(RECOV_CYC[src_kind_idx(op_kind)] - 1);
          end
        end
        DEV_HWRST: begin
          if (rstpin_s2_reg) begin
            state_reg <= DEV_RECOVER;
            recov_cnt_reg <= CNT_W'(RECOV_CYC[rec_kind_reg] - 1);
          end
        end
        DEV_RECOVER: begin
          if (hw_hit) begin
            state_reg <= DEV_HWRST;
          end else if (recov_cnt_reg == '0) begin
            state_reg <= DEV_READY;
          end else begin
            recov_cnt_reg <= recov_cnt_reg - 1'b1;
          end
        end
        default: state_reg <= DEV_READY;
      endcase
    end
  end

  // Armed state of the two-step software reset
  always_ff @(posedge ref_clk) begin
    if (sys_rst || reset_evt) begin
      armed_reg <= 1'b0;
      last_arm_reg <= 1'b0;
    end else if (cmd_ok) begin
      armed_reg <= (cmd_op_reg == OPC_RESET_ARM);
      last_arm_reg <= (cmd_op_reg == OPC_RESET_ARM);
    end else if (frame_end) begin
      armed_reg <= armed_reg && last_arm_reg;
      last_arm_reg <= 1'b0;
    end
  end

  // Write enable latch; no-op leaves it alone
  always_ff @(posedge ref_clk) begin
    if (sys_rst || reset_evt) begin
      latch_reg <= LATCH_RESET;
    end else if (cmd_ok && cmd_op_reg == OPC_WRITE_ENABLE) begin
      latch_reg <= 1'b1;
    end else if (cmd_ok && cmd_op_reg == OPC_WRITE_DISABLE) begin
      latch_reg <= 1'b0;
    end
  end

  // Quad command mode bit
  always_ff @(posedge ref_clk) begin
    if (sys_rst || reset_evt) begin
      quad_reg <= QUAD_RESET;
    end else if (cmd_ok && cmd_op_reg == OPC_QUAD_ENTER) begin
      quad_reg <= 1'b1;
    end else if (cmd_ok && cmd_op_reg == OPC_QUAD_EXIT) begin
      quad_reg <= 1'b0;
    end
  end

  // Abort and reset pulses, busy flag
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      abort_reg <= 1'b0;
      soft_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      abort_reg <= reset_evt && busy_op;
      soft_reg <= exec_now;
      busy_reg <= busy_op || (state_reg != DEV_READY) || reset_evt;
    end
  end

  assign ready = (state_reg == DEV_READY);
  assign hw_reset_active = (state_reg == DEV_HWRST);
  assign write_enable_latch = latch_reg;
  assign write_in_progress_flag = busy_reg;
  assign quad_mode = quad_reg;
  assign soft_reset = soft_reg;
  assign op_abort = abort_reg;

  // Link side: mode and status snapshot at frame start, stable all frame
  logic quad_frame_reg;
  logic [7:0] stat_frame_reg;
  always_ff @(negedge link.cs_n) begin
    quad_frame_reg <= quad_reg;
    stat_frame_reg <= 8'h00;
    stat_frame_reg[STAT_PROGRESS_BIT] <= busy_reg;
    stat_frame_reg[STAT_LATCH_BIT] <= latch_reg;
    stat_frame_reg[STAT_QUAD_BIT] <= quad_reg;
  end

  // Reset pin level on the link clock
  logic rst_l1_reg, rst_l2_reg;
  always_ff @(posedge link.sclk) begin
    rst_l1_reg <= link.reset_n;
    rst_l2_reg <= rst_l1_reg;
  end

  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic stat_act_reg;
  logic [7:0] stat_sh_reg;
  logic [3:0] last_idx;
  logic [7:0] next_op;
  logic last_clk;

  // Opcode assembly; upper lines ignored in single-line mode
  assign last_idx = quad_frame_reg ? QUAD_OPCODE_CLKS - 4'h1 : SPI_OPCODE_CLKS - 4'h1;
  assign next_op = quad_frame_reg ? {shift_reg[3:0], link.io} : {shift_reg[6:0], link.io[0]};
  assign last_clk = !done_reg && (bit_cnt_reg == last_idx);

  // Frame logic, cleared by chip select going high
  always_ff @(posedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      done_reg <= 1'b0;
      stat_act_reg <= 1'b0;
      stat_sh_reg <= 8'h00;
    end else begin
      shift_reg <= next_op;
      if (!done_reg) begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
      if (last_clk) begin
        done_reg <= 1'b1;
        stat_act_reg <= (next_op == OPC_READ_STATUS);
        stat_sh_reg <= stat_frame_reg;
      end else if (stat_act_reg) begin
        stat_sh_reg <= quad_frame_reg ? {stat_sh_reg[3:0], 4'h0} : {stat_sh_reg[6:0], 1'b0};
      end
    end
  end

  // Opcode word held for the reference domain after the done flag
  always_ff @(posedge link.sclk) begin
    if (last_clk) begin
      cmd_op_reg <= next_op;
    end
  end

  // Status drive from the falling edge after the opcode, once the host has let go; floated on reset
  logic drive_en;
  logic drive_ok_reg;
  always_ff @(negedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      drive_ok_reg <= 1'b0;
    end else begin
      drive_ok_reg <= stat_act_reg;
    end
  end
  assign drive_en = drive_ok_reg && rst_l2_reg && rstpin_s2_reg;
  assign link.dev_io_o = quad_frame_reg ? stat_sh_reg[7:4] : {2'b00, stat_sh_reg[7], 1'b0};
  assign link.dev_io_oe = quad_frame_reg ? {4{drive_en}} : {2'b00, drive_en, 1'b0};

endmodule : src_device

// [hw/src_host.sv]
`timescale 1ns/1ps
module src_host
  import src_pkg::*;
#(
  parameter int unsigned SCLK_HALF = SCLK_HALF_DEFAULT,
  parameter int unsigned RESET_LOW_CYC = RESET_LOW_WIDTH_CYC,
  parameter int unsigned RELEASE_CYC = RESET_RELEASE_TO_SELECT_CYC,
  parameter int unsigned PWRUP_CYC = POWER_UP_SELECT_DELAY_CYC,
  parameter int unsigned RECOV_CYC [0:6] = RECOV_CYC_DEFAULT
) (
  // System
  input wire logic ref_clk,
  input wire logic nrst,
  // Request
  input wire logic req_valid,
  input wire logic [1:0] req_kind,
  input wire logic [7:0] req_opcode,
  input wire logic req_read,
  input wire logic [2:0] req_op_kind,
  output logic req_ready,
  // Answer
  output logic done,
  output logic [7:0] rd_data,
  output logic quad_mode,
  // Flash link
  src_link_if.host link
);

  generate
    if (SCLK_HALF < 1 || SCLK_HALF > 255 || RESET_LOW_CYC < 1 || RELEASE_CYC < 1 ||
        PWRUP_CYC < 1) begin : g_bad
      $error("host timing parameter out of range");
    end
  endgenerate

  src_host_state_t st_reg;
  logic [CNT_W-1:0] wait_reg;
  logic [7:0] ph_reg;
  logic [3:0] clk_reg;
  logic [7:0] tx_reg, op_reg, rx_reg;
  logic rd_reg, seq_exec_reg, quad_reg, done_reg;
  logic sclk_reg, cs_n_reg, rst_n_reg;
  int kind_reg;
  logic [3:0] io_s1_reg, io_s2_reg;
  logic [3:0] n_op, total;
  logic half_end, wait_end;

  assign n_op = quad_reg ? QUAD_OPCODE_CLKS : SPI_OPCODE_CLKS;
  assign total = rd_reg ? {n_op[2:0], 1'b0} : n_op;
  assign half_end = (ph_reg == 8'(SCLK_HALF - 1));
  assign wait_end = (wait_reg == '0);

  // Read data into the reference domain
  always_ff @(posedge ref_clk) begin
    io_s1_reg <= link.io;
    io_s2_reg <= io_s1_reg;
  end

  // Sequencer for frames, resets and waits
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st_reg <= H_PWRUP;
      wait_reg <= CNT_W'(PWRUP_CYC - 1);
      ph_reg <= 8'h00;
      clk_reg <= 4'h0;
      tx_reg <= 8'h00;
      op_reg <= 8'h00;
      rx_reg <= 8'h00;
      rd_reg <= 1'b0;
      seq_exec_reg <= 1'b0;
      quad_reg <= 1'b0;
      done_reg <= 1'b0;
      sclk_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      rst_n_reg <= 1'b1;
      kind_reg <= 0;
    end else begin
      done_reg <= 1'b0;
      ph_reg <= half_end ? 8'h00 : ph_reg + 8'h01;
      if (!wait_end) begin
        wait_reg <= wait_reg - 1'b1;
      end
      case (st_reg)
        H_PWRUP: begin
          if (wait_end) begin
            st_reg <= H_IDLE;
          end
        end
        H_IDLE: begin
          ph_reg <= 8'h00;
          clk_reg <= 4'h0;
          kind_reg <= src_kind_idx(req_op_kind);
          if (req_valid && req_kind == REQ_HARD_RESET) begin
            rst_n_reg <= 1'b0;
            wait_reg <= CNT_W'(RESET_LOW_CYC - 1);
            st_reg <= H_RSTLOW;
          end else if (req_valid) begin
            seq_exec_reg <= (req_kind == REQ_SOFT_RESET);
            tx_reg <= (req_kind == REQ_SOFT_RESET) ? OPC_RESET_ARM : req_opcode;
            op_reg <= (req_kind == REQ_SOFT_RESET) ? OPC_RESET_ARM : req_opcode;
            rd_reg <= req_read && (req_kind == REQ_OPCODE);
            cs_n_reg <= 1'b0;
            st_reg <= H_LOW;
          end
        end
        H_LOW: begin
          if (half_end) begin
            sclk_reg <= 1'b1;
            st_reg <= H_HIGH;
            if (clk_reg >= n_op) begin
              rx_reg <= quad_reg ? {rx_reg[3:0], io_s2_reg} : {rx_reg[6:0], io_s2_reg[1]};
            end
          end
        end
        H_HIGH: begin
          if (half_end) begin
            sclk_reg <= 1'b0;
            if (clk_reg == total - 4'h1) begin
              wait_reg <= CNT_W'(CS_HOLD_CYC - 8'h01);
              st_reg <= H_HOLD;
            end else begin
              clk_reg <= clk_reg + 4'h1;
              tx_reg <= quad_reg ? {tx_reg[3:0], 4'h0} : {tx_reg[6:0], 1'b0};
              st_reg <= H_LOW;
            end
          end
        end
        H_HOLD: begin
          if (wait_end) begin
            cs_n_reg <= 1'b1;
            wait_reg <= CNT_W'(CS_GAP_CYC - 8'h01);
            st_reg <= H_GAP;
          end
        end
        H_GAP: begin
          ph_reg <= 8'h00;
          clk_reg <= 4'h0;
          if (wait_end && seq_exec_reg) begin
            seq_exec_reg <= 1'b0;
            tx_reg <= OPC_RESET_EXEC;
            op_reg <= OPC_RESET_EXEC;
            cs_n_reg <= 1'b0;
            st_reg <= H_LOW;
          end else if (wait_end && op_reg == OPC_RESET_EXEC) begin
            quad_reg <= QUAD_RESET;
            wait_reg <= CNT_W'(RECOV_CYC[kind_reg] - 1);
            st_reg <= H_WAIT;
          end else if (wait_end) begin
            if (op_reg == OPC_QUAD_ENTER) begin
              quad_reg <= 1'b1;
            end else if (op_reg == OPC_QUAD_EXIT) begin
              quad_reg <= 1'b0;
            end
            done_reg <= 1'b1;
            st_reg <= H_IDLE;
          end
        end
        H_RSTLOW: begin
          if (wait_end) begin
            rst_n_reg <= 1'b1;
            quad_reg <= QUAD_RESET;
            // Device recovery starts only after its pin synchroniser, so allow slack
            wait_reg <= (RECOV_CYC[kind_reg] + RECOV_MARGIN_CYC > RELEASE_CYC) ?
                        CNT_W'(RECOV_CYC[kind_reg] + RECOV_MARGIN_CYC - 1) :
                        CNT_W'(RELEASE_CYC - 1);
            st_reg <= H_WAIT;
          end
        end
        H_WAIT: begin
          if (wait_end) begin
            done_reg <= 1'b1;
            st_reg <= H_IDLE;
          end
        end
        default: st_reg <= H_IDLE;
      endcase
    end
  end

  // Outputs; opcode on line 0 only in single-line mode
  assign req_ready = (st_reg == H_IDLE);
  assign done = done_reg;
  assign rd_data = rx_reg;
  assign quad_mode = quad_reg;
  assign link.sclk = sclk_reg;
  assign link.cs_n = cs_n_reg;
  assign link.reset_n = rst_n_reg;
  assign link.host_io_o = quad_reg ? tx_reg[7:4] : {3'b000, tx_reg[7]};
  assign link.host_io_oe = ((st_reg == H_LOW || st_reg == H_HIGH) && clk_reg < n_op) ?
                           (quad_reg ? 4'hf : 4'h1) : 4'h0;

endmodule : src_host

// [hw/src_link_if.sv]
`timescale 1ns/1ps
interface src_link_if;
  logic sclk;
  logic cs_n;
  logic reset_n;
  logic [3:0] host_io_o;
  logic [3:0] host_io_oe;
  logic [3:0] dev_io_o;
  logic [3:0] dev_io_oe;
  logic [3:0] io;

  // Wire level with pull-ups when nobody drives
  assign io = (host_io_oe & host_io_o) | (~host_io_oe & dev_io_oe & dev_io_o) |
              (~host_io_oe & ~dev_io_oe);

  modport host (
    output sclk, cs_n, reset_n, host_io_o, host_io_oe,
    input io
  );
  modport device (
    input sclk, cs_n, reset_n, io,
    output dev_io_o, dev_io_oe
  );
endinterface : src_link_if

// [hw/src_pkg.sv]
// Behaviour
// - No-op only cancels a pending reset arm
// - No-op opcode takes 8 or 2 clocks
// - Software reset restores standby and power-on defaults
// - Execute acts only directly after arm
// - Arm and execute take 8 or 2 clocks
// - Software reset aborts running program or erase
// - Recovery after decode or read: 40 us
// - Recovery after program 310 us, status write 40 ms
// - Recovery after erases: 12, 25, 1000 ms
// - Reset pin low 10 us gives full reset
// - Hardware reset restores standby and volatile defaults
// - Hardware reset terminates running program or erase
// - Output floats while hardware reset is asserted
// - Host waits 10 us after release before select
// - Power-up gives standby with write latch cleared
// - Host waits power-up select delay before select
// - Below write-inhibit threshold, logic held, commands ignored
package src_pkg;

  // Clock rates
  localparam int REF_CLK_MHZ = 200;
  localparam int REF_PERIOD_NS = 5;
  localparam int SCLK_PERIOD_NS = 30;
  localparam int SCLK_HALF_DEFAULT = SCLK_PERIOD_NS / (2 * REF_PERIOD_NS);

  // Reset pin timing
  localparam int RESET_LOW_WIDTH_US = 10;
  localparam int RESET_LOW_WIDTH_CYC = RESET_LOW_WIDTH_US * REF_CLK_MHZ;
  localparam int RESET_RELEASE_TO_SELECT_US = 10;
  localparam int RESET_RELEASE_TO_SELECT_CYC = RESET_RELEASE_TO_SELECT_US * REF_CLK_MHZ;
  localparam int POWER_UP_SELECT_DELAY_US = 100;
  localparam int POWER_UP_SELECT_DELAY_CYC = POWER_UP_SELECT_DELAY_US * REF_CLK_MHZ;
  localparam int RECOV_MARGIN_CYC = 8; // Host slack for the device pin synchroniser

  // Recovery time after operation, per interrupted activity
  localparam int RECOV_DECODE_US = 40;
  localparam int RECOV_READ_US = 40;
  localparam int RECOV_PROGRAM_US = 310;
  localparam int RECOV_SE4K_MS = 12;
  localparam int RECOV_BE_MS = 25;
  localparam int RECOV_CE_MS = 1000;
  localparam int RECOV_SR_WRITE_MS = 40;
  localparam int unsigned RECOV_CYC_DEFAULT [0:6] = '{
    RECOV_DECODE_US * REF_CLK_MHZ,
    RECOV_READ_US * REF_CLK_MHZ,
    RECOV_PROGRAM_US * REF_CLK_MHZ,
    RECOV_SE4K_MS * 1000 * REF_CLK_MHZ,
    RECOV_BE_MS * 1000 * REF_CLK_MHZ,
    RECOV_CE_MS * 1000 * REF_CLK_MHZ,
    RECOV_SR_WRITE_MS * 1000 * REF_CLK_MHZ
  };
  localparam int CNT_W = 28;

  // Frame framing
  localparam logic [3:0] SPI_OPCODE_CLKS = 4'h8;
  localparam logic [3:0] QUAD_OPCODE_CLKS = 4'h2;
  localparam logic [7:0] CS_HOLD_CYC = 8'h04;
  localparam logic [7:0] CS_GAP_CYC = 8'h08;

  // Opcodes
  localparam logic [7:0] OPC_RESET_ARM = 8'h66;
  localparam logic [7:0] OPC_RESET_EXEC = 8'h99;
  localparam logic [7:0] OPC_NO_OPERATION = 8'h00;
  localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OPC_QUAD_ENTER = 8'h35;
  localparam logic [7:0] OPC_QUAD_EXIT = 8'hf5;
  localparam logic [7:0] OPC_READ_STATUS = 8'h05;

  // Status byte layout and reset values
  localparam int STAT_PROGRESS_BIT = 0;
  localparam int STAT_LATCH_BIT = 1;
  localparam int STAT_QUAD_BIT = 2;
  localparam logic LATCH_RESET = 1'b0;
  localparam logic QUAD_RESET = 1'b0;

  // Activity of the array engine
  typedef enum logic [2:0] {
    OP_IDLE, OP_READ, OP_PROGRAM, OP_SE4K, OP_BE, OP_CE, OP_SR_WRITE
  } src_op_t;

  typedef enum logic [1:0] {REQ_OPCODE, REQ_SOFT_RESET, REQ_HARD_RESET} src_req_t;
  typedef enum {DEV_READY, DEV_HWRST, DEV_RECOVER} src_dev_state_t;
  typedef enum {H_PWRUP, H_IDLE, H_LOW, H_HIGH, H_HOLD, H_GAP, H_RSTLOW, H_WAIT} src_host_state_t;

  // Folds undefined activity codes onto idle
  function automatic int src_kind_idx(input logic [2:0] kind);
    return (kind > OP_SR_WRITE) ? 0 : int'(kind);
  endfunction : src_kind_idx

endpackage : src_pkg

// [testbench/src_link_assertions.sv]
`timescale 1ns/1ps
module src_link_assertions #(
  parameter int unsigned RESET_LOW_CYC = 20,
  parameter int unsigned RELEASE_CYC = 20,
  parameter int unsigned PWRUP_CYC = 10
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic reset_n,
  input wire logic [3:0] host_io_oe,
  input wire logic [3:0] dev_io_oe
);
  logic sclk_q;
  logic [4:0] clk_cnt;
  logic [15:0] lo_cnt;
  logic [15:0] hi_cnt;
  logic [15:0] up_cnt;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // Link clock rises counted per frame
  always_ff @(posedge ref_clk) begin
    sclk_q <= sclk;
    if (!nrst || cs_n) clk_cnt <= 5'h00;
    else if (sclk && !sclk_q && clk_cnt != 5'h1f) clk_cnt <= clk_cnt + 5'h01;
  end

  // Reset pin low and high run lengths; only the high count saturates
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      lo_cnt <= 16'h0000;
      hi_cnt <= 16'hffff;
    end else if (!reset_n) begin
      lo_cnt <= lo_cnt + 16'h0001;
      hi_cnt <= 16'h0000;
    end else begin
      lo_cnt <= 16'h0000;
      if (hi_cnt != 16'hffff) hi_cnt <= hi_cnt + 16'h0001;
    end
  end

  // Cycles since power-up release
  always_ff @(posedge ref_clk) begin
    if (!nrst) up_cnt <= 16'h0000;
    else if (up_cnt != 16'hffff) up_cnt <= up_cnt + 16'h0001;
  end

  // Frame and pin events
  sequence frame_open;
    $fell(cs_n);
  endsequence
  sequence frame_close;
    $rose(cs_n);
  endsequence
  sequence pin_release;
    $rose(reset_n);
  endsequence

  rst_width_a: assert property (pin_release |-> lo_cnt >= RESET_LOW_CYC)
    else $error("reset pin pulse too short");
  rst_select_a: assert property (frame_open |-> hi_cnt >= RELEASE_CYC)
    else $error("select too soon after reset release");
  pwrup_select_a: assert property (frame_open |-> up_cnt >= PWRUP_CYC)
    else $error("select too soon after power-up");
  rst_no_frame_a: assert property (!reset_n |-> cs_n)
    else $error("select while reset pin low");
  frame_clocks_a: assert property (frame_close |->
    clk_cnt inside {5'h02, 5'h04, 5'h08, 5'h10}) else $error("frame clock count wrong");
  sclk_idle_a: assert property (cs_n |-> !sclk)
    else $error("link clock runs outside frame");
  dev_float_a: assert property (!reset_n [*3] |-> dev_io_oe == 4'h0)
    else $error("device drives during reset");
  no_clash_a: assert property ((host_io_oe & dev_io_oe) == 4'h0)
    else $error("both ends drive io");
  oe_shape_a: assert property (!cs_n && host_io_oe != 4'h0 |->
    host_io_oe inside {4'h1, 4'hf}) else $error("host drive width wrong");
endmodule : src_link_assertions

// [testbench/src_test.sv]
`timescale 1ns/1ps
module src_test;
  import src_pkg::*;
  localparam int unsigned RC [0:6] = '{40, 44, 48, 52, 56, 60, 64};
  localparam int unsigned LOW_CYC = 20;
  localparam int unsigned REL_CYC = 20;
  localparam int unsigned UP_CYC = 10;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic supply_ok = 1'b1;
  logic [2:0] op_kind = 3'h0;
  logic req_valid = 1'b0;
  logic [1:0] req_kind = 2'h0;
  logic [7:0] req_opcode = 8'h00;
  logic req_read = 1'b0;
  logic [2:0] req_op_kind = 3'h0;
  logic req_ready, done, h_quad, ready, d_quad, hw_act, soft_reset, op_abort;
  logic write_enable_latch, write_in_progress_flag;
  logic [7:0] rd_data;
  int fails = 0;
  int n_compared = 0;
  int cyc = 0;
  int n_soft = 0;
  int n_abort = 0;
  int n_hw = 0;
  int low_run = 0;
  int last_low = 0;

  src_link_if link ();

  always #2.5 ref_clk = ~ref_clk;

  src_host #(.SCLK_HALF(3), .RESET_LOW_CYC(LOW_CYC), .RELEASE_CYC(REL_CYC),
    .PWRUP_CYC(UP_CYC), .RECOV_CYC(RC)) u_src_host (.ref_clk(ref_clk), .nrst(nrst),
    .req_valid(req_valid), .req_kind(req_kind), .req_opcode(req_opcode),
    .req_read(req_read), .req_op_kind(req_op_kind), .req_ready(req_ready), .done(done),
    .rd_data(rd_data), .quad_mode(h_quad), .link(link.host));
  src_device #(.RESET_LOW_CYC(LOW_CYC), .RECOV_CYC(RC)) u_src_device (.ref_clk(ref_clk),
    .nrst(nrst), .supply_ok(supply_ok), .op_kind(op_kind), .link(link.device),
    .ready(ready), .write_enable_latch(write_enable_latch),
    .write_in_progress_flag(write_in_progress_flag), .quad_mode(d_quad), .hw_reset_active(hw_act),
    .soft_reset(soft_reset), .op_abort(op_abort));
  src_link_assertions #(.RESET_LOW_CYC(LOW_CYC), .RELEASE_CYC(REL_CYC), .PWRUP_CYC(UP_CYC))
    u_src_link_assertions (.ref_clk(ref_clk), .nrst(nrst), .sclk(link.sclk),
    .cs_n(link.cs_n), .reset_n(link.reset_n), .host_io_oe(link.host_io_oe),
    .dev_io_oe(link.dev_io_oe));

  // Event counts, recovery length and hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (soft_reset === 1'b1) n_soft++;
    if (op_abort === 1'b1) n_abort++;
    if (hw_act === 1'b1) n_hw++;
    if (ready === 1'b0) low_run++;
    else if (low_run != 0) begin
      last_low = low_run;
      low_run = 0;
    end
    if (cyc == 20000) begin
      fails++;
      results();
    end
  end

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // One host request, raised for one cycle once ready is seen, then wait for done
  task automatic req(input logic [1:0] k, input logic [7:0] opc, input logic rd,
                     input logic [2:0] ok);
    int t;
    t = 0;
    @(negedge ref_clk);
    while (req_ready !== 1'b1 && t < 5000) begin
      @(negedge ref_clk);
      t++;
    end
    req_valid = 1'b1;
    req_kind = k;
    req_opcode = opc;
    req_read = rd;
    req_op_kind = ok;
    @(negedge ref_clk);
    req_valid = 1'b0;
    t = 0;
    while (done !== 1'b1 && t < 5000) begin
      @(posedge ref_clk);
      #1;
      t++;
    end
    check("done", 8'h01, {7'h00, done});
  endtask : req

  task automatic op(input logic [7:0] opc);
    req(2'h0, opc, 1'b0, 3'h0);
  endtask : op

  task automatic status(input logic [7:0] exp);
    req(2'h0, OPC_READ_STATUS, 1'b1, 3'h0);
    check("status", exp, rd_data);
  endtask : status

  task automatic t_power_up();
    check("ready", 8'h01, {7'h00, ready});
    status(8'h00);
  endtask : t_power_up

  task automatic t_noop();
    op(OPC_WRITE_ENABLE);
    op(OPC_NO_OPERATION);
    status(8'h02);
    op(OPC_RESET_ARM);
    op(OPC_NO_OPERATION);
    op(OPC_RESET_EXEC);
    status(8'h02);
    op(OPC_RESET_ARM);
    status(8'h02);
    op(OPC_RESET_EXEC);
    status(8'h02);
    check("reset pulse", 8'h00, 8'(n_soft));
  endtask : t_noop

  task automatic t_soft_kinds();
    int s0;
    int a0;
    int t;
    for (int k = 0; k < 7; k++) begin
      op(OPC_WRITE_ENABLE);
      s0 = n_soft;
      a0 = n_abort;
      @(negedge ref_clk);
      op_kind = k[2:0];
      req(2'h1, 8'h00, 1'b0, k[2:0]);
      t = 0;
      while (ready !== 1'b1 && t < 500) begin
        @(posedge ref_clk);
        #1;
        t++;
      end
      check("reset pulse", 8'h01, 8'(n_soft - s0));
      check("abort", {7'h00, k >= 2}, 8'(n_abort - a0));
      check("recovery", 8'h01, {7'h00, last_low >= int'(RC[k])});
      check("write latch", 8'h00, {7'h00, write_enable_latch});
      @(negedge ref_clk);
      op_kind = 3'h0;
    end
  endtask : t_soft_kinds

  task automatic t_quad();
    op(OPC_QUAD_ENTER);
    check("quad", 8'h01, {7'h00, d_quad});
    op(OPC_WRITE_ENABLE);
    status(8'h06);
    req(2'h1, 8'h00, 1'b0, 3'h0);
    check("quad", 8'h00, {7'h00, d_quad});
    status(8'h00);
  endtask : t_quad

  task automatic t_hard();
    int a0;
    op(OPC_WRITE_ENABLE);
    a0 = n_abort;
    @(negedge ref_clk);
    op_kind = 3'h3;
    req(2'h2, 8'h00, 1'b0, 3'h3);
    check("hw reset seen", 8'h01, {7'h00, n_hw > 0});
    check("recovery", 8'h01, {7'h00, last_low >= int'(RC[3])});
    check("abort", 8'h01, 8'(n_abort - a0));
    @(negedge ref_clk);
    op_kind = 3'h0;
    status(8'h00);
  endtask : t_hard

  task automatic t_supply();
    @(negedge ref_clk);
    supply_ok = 1'b0;
    repeat (4) @(negedge ref_clk);
    op(OPC_WRITE_ENABLE);
    @(negedge ref_clk);
    supply_ok = 1'b1;
    repeat (4) @(negedge ref_clk);
    status(8'h00);
  endtask : t_supply

  task automatic results();
    $display("compared %0d fails %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results

  // Main sequence
  initial begin
    repeat (3) @(negedge ref_clk);
    nrst = 1'b1;
    t_power_up();
    t_noop();
    t_soft_kinds();
    t_quad();
    t_hard();
    t_supply();
    results();
  end
endmodule : src_test
